//--- logic/reset_cause_pkg.sv
// Package with offsets, field positions, reset values and types of the block.
package reset_cause_pkg;

	// Register offsets on the plain register port.
	localparam int          REG_ADDR_W   = 2;
	localparam logic [1:0]  OFS_CTRL     = 2'h0;
	localparam logic [1:0]  OFS_IRQ_STAT = 2'h1;
	localparam logic [1:0]  OFS_IRQ_MASK = 2'h2;

	// Field positions of the reset cause control register.
	localparam int          BIT_PRIO_EN  = 7;
	localparam int          BIT_SWRST    = 4;
	localparam int          BIT_WDOG     = 3;
	localparam int          BIT_PDOWN    = 2;
	localparam int          BIT_POR      = 1;
	localparam int          BIT_BROWN    = 0;

	// Reset values and implemented-bit masks.
	localparam logic [7:0]  CTRL_RST     = 8'h1c;
	localparam logic [7:0]  CTRL_IMPL    = 8'h9f;
	localparam logic [7:0]  IRQ_IMPL     = 8'h1f;
	localparam logic [7:0]  IRQ_RST      = 8'h00;
	localparam logic        PRIO_EN_RST  = 1'b0;
	localparam logic        SWRST_RST    = 1'b1;
	localparam logic        WDOG_RST     = 1'b1;
	localparam logic        PDOWN_RST    = 1'b1;
	localparam logic        POR_RST      = 1'b0;
	localparam logic        BROWN_RST    = 1'b0;

	// Single-cycle events from the core, all on clk_i.
	typedef struct packed {
		logic sw_reset_instr;
		logic watchdog_timeout;
		logic sleep_instr;
		logic clear_watchdog_instr;
		logic power_on_reset;
		logic brown_out_reset;
	} core_evt_t;

endpackage

//--- logic/flag_cell.sv
// One reset cause flag: hardware clear, hardware set and software write.
`timescale 1ns/1ps
module flag_cell #(
	parameter logic RST_VAL = 1'b1
) (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_b_i,
	// Hardware events
	input  wire logic hw_clr_i,
	input  wire logic hw_set_i,
	// Software write
	input  wire logic sw_we_i,
	input  wire logic sw_val_i,
	// Flag
	output logic      flag_o
);

	logic flag_d;
	logic flag_q;

	// A hardware event wins over a software write in the same cycle, so a
	// re-arm never hides a reset cause that has just happened.
	always_comb begin
		flag_d = flag_q;
		if (hw_clr_i) begin
			flag_d = 1'b0;
		end else if (hw_set_i) begin
			flag_d = 1'b1;
		end else if (sw_we_i) begin
			flag_d = sw_val_i;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			flag_q <= RST_VAL;
		end else begin
			flag_q <= flag_d;
		end
	end

	assign flag_o = flag_q;

	a_clear_wins: assert property (@(posedge clk_i)
		disable iff (!rst_b_i)
		hw_clr_i |=> !flag_o)
		else $error("flag not cleared by hardware event");

endmodule // flag_cell

//--- logic/reset_cause_flags.sv
// Reset cause control register with sticky event interrupts.
//
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// How it works
// - Flags tell which source caused last reset.
// - Implemented bits are readable and writable by software.
// - Bit 7 enables two interrupt priority levels.
// - Bits 6 and 5 read zero, ignore writes.
// - Reset instruction clears bit 4.
// - Power-on reset clears bit 1; software re-arms.
////////////////////////////////////////////////////////////////////////////////
module reset_cause_flags
	import reset_cause_pkg::*;
(
	// Clock and reset
	input  wire logic                  clk_i,
	input  wire logic                  rst_b_i,
	// Register port
	input  wire logic [REG_ADDR_W-1:0] reg_addr_i,
	input  wire logic [7:0]            reg_wdata_i,
	input  wire logic                  reg_wr_i,
	input  wire logic                  reg_rd_i,
	output logic      [7:0]            reg_rdata_o,
	// Core events
	input  wire core_evt_t             evt_i,
	// Status towards the core
	output logic      [7:0]            reset_cause_o,
	output logic                       irq_priority_enable_o,
	output logic                       irq_o
);

	////////////////////////////////////////////////////////////////////////
	// Register decode.

	logic wr_ctrl;
	logic wr_stat;
	logic wr_mask;

	assign wr_ctrl = reg_wr_i && (reg_addr_i == OFS_CTRL);
	assign wr_stat = reg_wr_i && (reg_addr_i == OFS_IRQ_STAT);
	assign wr_mask = reg_wr_i && (reg_addr_i == OFS_IRQ_MASK);

	////////////////////////////////////////////////////////////////////////
	// Reset cause flags.

	logic sw_reset_instr_flag;
	logic watchdog_timeout_flag;
	logic power_down_flag;
	logic power_on_flag;
	logic brown_out_flag;
	logic wdog_set;
	logic pdown_set;

	assign wdog_set  = evt_i.clear_watchdog_instr || evt_i.sleep_instr;
	assign pdown_set = evt_i.clear_watchdog_instr;

	flag_cell #(.RST_VAL(SWRST_RST)) u_swrst (
		.clk_i    (clk_i),
		.rst_b_i  (rst_b_i),
		.hw_clr_i (evt_i.sw_reset_instr),
		.hw_set_i (1'b0),
		.sw_we_i  (wr_ctrl),
		.sw_val_i (reg_wdata_i[BIT_SWRST]),
		.flag_o   (sw_reset_instr_flag)
	);

	flag_cell #(.RST_VAL(WDOG_RST)) u_wdog (
		.clk_i    (clk_i),
		.rst_b_i  (rst_b_i),
		.hw_clr_i (evt_i.watchdog_timeout),
		.hw_set_i (wdog_set),
		.sw_we_i  (wr_ctrl),
		.sw_val_i (reg_wdata_i[BIT_WDOG]),
		.flag_o   (watchdog_timeout_flag)
	);

	flag_cell #(.RST_VAL(PDOWN_RST)) u_pdown (
		.clk_i    (clk_i),
		.rst_b_i  (rst_b_i),
		.hw_clr_i (evt_i.sleep_instr),
		.hw_set_i (pdown_set),
		.sw_we_i  (wr_ctrl),
		.sw_val_i (reg_wdata_i[BIT_PDOWN]),
		.flag_o   (power_down_flag)
	);

	flag_cell #(.RST_VAL(POR_RST)) u_por (
		.clk_i    (clk_i),
		.rst_b_i  (rst_b_i),
		.hw_clr_i (evt_i.power_on_reset),
		.hw_set_i (1'b0),
		.sw_we_i  (wr_ctrl),
		.sw_val_i (reg_wdata_i[BIT_POR]),
		.flag_o   (power_on_flag)
	);

	flag_cell #(.RST_VAL(BROWN_RST)) u_brown (
		.clk_i    (clk_i),
		.rst_b_i  (rst_b_i),
		.hw_clr_i (evt_i.brown_out_reset),
		.hw_set_i (1'b0),
		.sw_we_i  (wr_ctrl),
		.sw_val_i (reg_wdata_i[BIT_BROWN]),
		.flag_o   (brown_out_flag)
	);

	////////////////////////////////////////////////////////////////////////
	// Priority enable, interrupt status, mask and read data.

	logic       prio_en_d;
	logic       prio_en_q;
	logic [7:0] stat_d;
	logic [7:0] stat_q;
	logic [7:0] mask_d;
	logic [7:0] mask_q;
	logic       irq_d;
	logic       irq_q;
	logic [7:0] rdata_d;
	logic [7:0] rdata_q;
	logic [7:0] ctrl_view;
	logic [7:0] evt_bits;

	// Bits 6 and 5 are tied low, so they read zero and ignore writes.
	always_comb begin
		ctrl_view              = 8'h00;
		ctrl_view[BIT_PRIO_EN] = prio_en_q;
		ctrl_view[BIT_SWRST]   = sw_reset_instr_flag;
		ctrl_view[BIT_WDOG]    = watchdog_timeout_flag;
		ctrl_view[BIT_PDOWN]   = power_down_flag;
		ctrl_view[BIT_POR]     = power_on_flag;
		ctrl_view[BIT_BROWN]   = brown_out_flag;
	end

	always_comb begin
		evt_bits          = 8'h00;
		evt_bits[BIT_SWRST] = evt_i.sw_reset_instr;
		evt_bits[BIT_WDOG]  = evt_i.watchdog_timeout;
		evt_bits[BIT_PDOWN] = evt_i.sleep_instr;
		evt_bits[BIT_POR]   = evt_i.power_on_reset;
		evt_bits[BIT_BROWN] = evt_i.brown_out_reset;
	end

	always_comb begin
		prio_en_d = prio_en_q;
		if (wr_ctrl) begin
			prio_en_d = reg_wdata_i[BIT_PRIO_EN];
		end
		stat_d = stat_q;
		if (wr_stat) begin
			stat_d = stat_q & ~reg_wdata_i;
		end
		// A new event wins over a clear written in the same cycle.
		stat_d = (stat_d | evt_bits) & IRQ_IMPL;
		mask_d = mask_q;
		if (wr_mask) begin
			mask_d = reg_wdata_i & IRQ_IMPL;
		end
		irq_d = |(stat_d & mask_d);
		rdata_d = 8'h00;
		if (reg_rd_i) begin
			case (reg_addr_i)
				OFS_CTRL:     rdata_d = ctrl_view & CTRL_IMPL;
				OFS_IRQ_STAT: rdata_d = stat_q;
				OFS_IRQ_MASK: rdata_d = mask_q;
				default:      rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			prio_en_q <= PRIO_EN_RST;
			stat_q  <= IRQ_RST;
			mask_q  <= IRQ_RST;
			irq_q   <= 1'b0;
			rdata_q <= 8'h00;
		end else begin
			prio_en_q <= prio_en_d;
			stat_q  <= stat_d;
			mask_q  <= mask_d;
			irq_q   <= irq_d;
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata_o           = rdata_q;
	assign reset_cause_o         = ctrl_view;
	assign irq_priority_enable_o = prio_en_q;
	assign irq_o                 = irq_q;

	////////////////////////////////////////////////////////////////////////
	// Assertions.

	a_swrst_clear: assert property (@(posedge clk_i)
		disable iff (!rst_b_i)
		evt_i.sw_reset_instr |=> !reset_cause_o[BIT_SWRST])
		else $error("reset instruction did not clear its flag");

	a_wdog_clear: assert property (@(posedge clk_i)
		disable iff (!rst_b_i)
		evt_i.watchdog_timeout |=> !reset_cause_o[BIT_WDOG])
		else $error("watchdog time-out did not clear its flag");

	a_wdog_set_instr: assert property (@(posedge clk_i)
		disable iff (!rst_b_i)
		wdog_set && !evt_i.watchdog_timeout |=> reset_cause_o[BIT_WDOG])
		else $error("time-out flag not set by instruction");

	a_pdown_sleep_clear: assert property (@(posedge clk_i)
		disable iff (!rst_b_i)
		evt_i.sleep_instr |=> !reset_cause_o[BIT_PDOWN])
		else $error("sleep did not clear power-down flag");

	a_pdown_wdog_set: assert property (@(posedge clk_i)
		disable iff (!rst_b_i)
		pdown_set && !evt_i.sleep_instr |=> reset_cause_o[BIT_PDOWN])
		else $error("clear-watchdog did not set power-down flag");

	a_por_hw_clear: assert property (@(posedge clk_i)
		disable iff (!rst_b_i)
		evt_i.power_on_reset |=> !reset_cause_o[BIT_POR])
		else $error("power-on reset did not clear its flag");

	a_brown_rearm: assert property (@(posedge clk_i)
		disable iff (!rst_b_i)
		wr_ctrl && !evt_i.brown_out_reset
		|=> reset_cause_o[BIT_BROWN] == $past(reg_wdata_i[BIT_BROWN]))
		else $error("brown-out flag not re-armed by write");

	a_unimpl_zero: assert property (@(posedge clk_i)
		disable iff (!rst_b_i)
		reg_rd_i && reg_addr_i == OFS_CTRL |=> reg_rdata_o[6:5] == 2'b00)
		else $error("unimplemented bits read nonzero");

	// The write lands at its own edge, so two edges later the enable
	// must still hold the data that stood beside that write strobe.
	a_prio_en_write: assert property (@(posedge clk_i)
		disable iff (!rst_b_i)
		wr_ctrl ##1 !wr_ctrl[*2]
		|-> irq_priority_enable_o == $past(reg_wdata_i[BIT_PRIO_EN], 2))
		else $error("priority enable does not hold written value");

	a_ctrl_readback: assert property (@(posedge clk_i)
		disable iff (!rst_b_i)
		reg_rd_i && reg_addr_i == OFS_CTRL
		|=> reg_rdata_o == ($past(reset_cause_o) & CTRL_IMPL))
		else $error("control read data differs from flags");

	a_irq_level: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		irq_o == |(stat_q & mask_q))
		else $error("interrupt output disagrees with status and mask");

	c_sw_reset: cover property (@(posedge clk_i) disable iff (!rst_b_i)
		evt_i.sw_reset_instr ##1 reg_rd_i && reg_addr_i == OFS_CTRL);

	c_brown_rearm: cover property (@(posedge clk_i) disable iff (!rst_b_i)
		evt_i.brown_out_reset ##[1:20] wr_ctrl && reg_wdata_i[BIT_BROWN]);

	c_irq_raise: cover property (@(posedge clk_i) disable iff (!rst_b_i)
		!irq_o ##1 irq_o);

endmodule // reset_cause_flags

//--- bench/tb.sv
// Randomised self-checking bench for the reset cause register block.
`timescale 1ns/1ps
module tb
	import reset_cause_pkg::*;
;
	// Starting at zero in the declaration avoids a false edge at time 0.
	logic                  clk_i = 1'b0;
	logic                  rst_b_i = 1'b0;
	logic [REG_ADDR_W-1:0] reg_addr_i;
	logic [7:0]            reg_wdata_i;
	logic                  reg_wr_i;
	logic                  reg_rd_i;
	logic [7:0]            reg_rdata_o;
	core_evt_t             evt_i;
	logic [7:0]            reset_cause_o;
	logic                  irq_priority_enable_o;
	logic                  irq_o;
	logic [7:0]            m_ctrl, m_stat, m_mask, m_rd;
	logic [31:0]           r;
	int                    bad_count, tests_run, seed, cycles;

	reset_cause_flags dut (
		.clk_i                 (clk_i),
		.rst_b_i               (rst_b_i),
		.reg_addr_i            (reg_addr_i),
		.reg_wdata_i           (reg_wdata_i),
		.reg_wr_i              (reg_wr_i),
		.reg_rd_i              (reg_rd_i),
		.reg_rdata_o           (reg_rdata_o),
		.evt_i                 (evt_i),
		.reset_cause_o         (reset_cause_o),
		.irq_priority_enable_o (irq_priority_enable_o),
		.irq_o                 (irq_o)
	);

	always #2.5 clk_i = ~clk_i;

	////////////////////////////////////////
	task automatic check(input string what, input logic [7:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Hardware clears win over hardware sets, which win over the write.
	function automatic logic [7:0] next_ctrl(input logic [7:0] c,
		input core_evt_t e, input logic we, input logic [7:0] wd);
		logic [7:0] n;
		n = we ? (wd & CTRL_IMPL) : c;
		if (e.clear_watchdog_instr || e.sleep_instr)
			n[BIT_WDOG] = 1'b1;
		if (e.clear_watchdog_instr) n[BIT_PDOWN] = 1'b1;
		if (e.sw_reset_instr) n[BIT_SWRST] = 1'b0;
		if (e.watchdog_timeout) n[BIT_WDOG] = 1'b0;
		if (e.sleep_instr) n[BIT_PDOWN] = 1'b0;
		if (e.power_on_reset) n[BIT_POR] = 1'b0;
		if (e.brown_out_reset) n[BIT_BROWN] = 1'b0;
		return n;
	endfunction

	// Reference model follows the same port traffic as the block.
	always @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			m_ctrl = CTRL_RST;
			m_stat = 8'h00;
			m_mask = 8'h00;
			m_rd = 8'h00;
		end else begin
			m_rd = 8'h00;
			if (reg_rd_i && reg_addr_i == OFS_CTRL) m_rd = m_ctrl;
			if (reg_rd_i && reg_addr_i == OFS_IRQ_STAT) m_rd = m_stat;
			if (reg_rd_i && reg_addr_i == OFS_IRQ_MASK) m_rd = m_mask;
			m_ctrl = next_ctrl(m_ctrl, evt_i,
				reg_wr_i && reg_addr_i == OFS_CTRL, reg_wdata_i);
			if (reg_wr_i && reg_addr_i == OFS_IRQ_STAT)
				m_stat = m_stat & ~reg_wdata_i;
			m_stat = m_stat | {3'b000, evt_i.sw_reset_instr,
				evt_i.watchdog_timeout, evt_i.sleep_instr,
				evt_i.power_on_reset, evt_i.brown_out_reset};
			if (reg_wr_i && reg_addr_i == OFS_IRQ_MASK)
				m_mask = reg_wdata_i & IRQ_IMPL;
		end
	end

	always @(negedge clk_i) begin
		check("rdata", reg_rdata_o, m_rd);
		check("control", reset_cause_o, m_ctrl);
		check("prio_en", {7'h00, irq_priority_enable_o},
			{7'h00, m_ctrl[BIT_PRIO_EN]});
		check("irq", {7'h00, irq_o}, {7'h00, |(m_stat & m_mask)});
		cycles++;
		if (cycles > 10000) begin
			bad_count++;
			wrap_up();
		end
	end

	task automatic drive(input logic wr, rd, input logic [1:0] a,
		input logic [7:0] wd, input core_evt_t e);
		@(posedge clk_i);
		reg_wr_i <= wr;
		reg_rd_i <= rd;
		reg_addr_i <= a;
		reg_wdata_i <= wd;
		evt_i <= e;
	endtask

	////////////////////////////////////////
	initial begin
		reg_addr_i = '0;
		reg_wdata_i = 8'h00;
		reg_wr_i = 1'b0;
		reg_rd_i = 1'b0;
		evt_i = '0;
		seed = 32'hfd2b;
		repeat (3) @(posedge clk_i);
		rst_b_i <= 1'b1;
		for (int i = 0; i < 4; i++) drive(0, 1, 2'(i), 8'h00, '0);
		drive(1, 0, OFS_CTRL, 8'hff, '0);
		drive(0, 1, OFS_CTRL, 8'h00, '0);
		drive(1, 0, OFS_CTRL, 8'h00, '0);
		drive(1, 0, OFS_IRQ_MASK, 8'hff, '0);
		for (int i = 0; i < 6; i++) begin
			drive(0, 0, OFS_CTRL, 8'h00, core_evt_t'(6'h01 << i));
			drive(0, 1, OFS_IRQ_STAT, 8'h00, '0);
			// Event set must beat the same-edge clear.
			drive(1, 0, OFS_IRQ_STAT, 8'hff, core_evt_t'(6'h01 << i));
			drive(1, 0, OFS_IRQ_STAT, 8'hff, '0);
			drive(1, 0, OFS_CTRL, 8'h9f, core_evt_t'(6'h01 << i));
			drive(1, 0, OFS_CTRL, 8'h1f, '0);
		end
		drive(1, 0, OFS_IRQ_MASK, 8'h01, core_evt_t'(6'h02));
		drive(0, 1, OFS_IRQ_MASK, 8'h00, core_evt_t'(6'h01));
		drive(1, 0, OFS_IRQ_STAT, 8'h1f, '0);
		rst_b_i <= 1'b0;
		drive(0, 0, OFS_CTRL, 8'h00, '0);
		drive(0, 0, OFS_CTRL, 8'h00, '0);
		rst_b_i <= 1'b1;
		for (int n = 0; n < 3000; n++) begin
			r = $random(seed);
			drive(r[1:0] == 2'd1, r[1:0] == 2'd2, r[3:2], r[11:4],
				core_evt_t'(r[17:12] & r[23:18] & r[29:24]));
		end
		drive(0, 0, OFS_CTRL, 8'h00, '0);
		@(posedge clk_i);
		@(posedge clk_i);
		wrap_up();
	end
endmodule // tb
